// File: src/jpe_pkg.sv
package jpe_pkg;

  // runtime enable register, offset from the i/o register base
  localparam logic [7:0] JPE_RT_EN_OFFSET = 8'hc7;
  localparam int JPE_RT_EN_BIT = 0;
  localparam logic [7:0] JPE_RT_EN_RESET = 8'h00;
  localparam logic [7:0] JPE_RT_EN_MASK = 8'h01;

  // instruction register width and opcodes of the configuration channel
  localparam int JPE_IR_W = 8;
  localparam logic [7:0] JPE_OP_ENTRY = 8'h0c;
  localparam logic [7:0] JPE_OP_EXIT = 8'h0f;
  localparam logic [7:0] JPE_OP_CLEAR = 8'h10;
  localparam logic [7:0] JPE_OP_CHIP_ERASE = 8'h11;
  localparam logic [7:0] JPE_OP_SECT_ERASE = 8'h12;
  localparam logic [7:0] JPE_OP_PROGRAM = 8'h13;
  localparam logic [7:0] JPE_OP_READ = 8'h14;
  localparam logic [7:0] JPE_OP_VERIFY = 8'h15;
  localparam logic [7:0] JPE_OP_BYPASS = 8'hff;

  // data register: sector index in low bits, entry options in bits 0 and 1
  localparam int JPE_DR_W = 8;
  localparam int JPE_SECT_N = 12;
  localparam int JPE_SECT_W = 4;
  localparam int JPE_OPT_SIDEBAND = 0;
  localparam int JPE_OPT_OPEN_DRAIN = 1;

  // synchroniser depth and instruction register capture value
  localparam int JPE_SYNC_STAGES = 2;
  localparam logic [7:0] JPE_IR_CAPTURE = 8'h01;

  typedef enum logic [3:0] {
    JPE_TLR, JPE_RTI, JPE_SEL_DR, JPE_CAP_DR, JPE_SH_DR, JPE_EX1_DR, JPE_PA_DR, JPE_EX2_DR, JPE_UPD_DR,
    JPE_SEL_IR, JPE_CAP_IR, JPE_SH_IR, JPE_EX1_IR, JPE_PA_IR, JPE_EX2_IR, JPE_UPD_IR
  } jpe_tap_e;

  typedef struct packed {
    logic tms;
    logic tck;
    logic tdi;
  } jpe_link_s;

  typedef struct packed {
    logic start;
    logic is_erase;
    logic is_program;
    logic is_chip;
    logic [3:0] sector;
  } jpe_memop_s;

endpackage

// File: src/jpe_sync.sv
`timescale 1ns/100ps
module jpe_sync (
  input wire logic clk,
  input wire logic rst,
  input wire jpe_pkg::jpe_link_s din,
  output jpe_pkg::jpe_link_s dout,
  output logic tck_rise,
  output logic tck_fall
);
  jpe_pkg::jpe_link_s meta_reg;
  jpe_pkg::jpe_link_s sync_reg;
  logic tck_prev_reg;

  // two stages before any logic looks at the pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tck_prev_reg <= 1'b0;
    end else begin
      tck_prev_reg <= sync_reg.tck;
    end
  end

  assign dout = sync_reg;
  assign tck_rise = sync_reg.tck & ~tck_prev_reg;
  assign tck_fall = ~sync_reg.tck & tck_prev_reg;
endmodule

// File: src/jpe_tap.sv
`timescale 1ns/100ps
module jpe_tap (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic tms,
  input wire logic tck_rise,
  output jpe_pkg::jpe_tap_e state
);
  jpe_pkg::jpe_tap_e state_reg;
  jpe_pkg::jpe_tap_e state_next;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      jpe_pkg::JPE_TLR: state_next = tms ? jpe_pkg::JPE_TLR : jpe_pkg::JPE_RTI;
      jpe_pkg::JPE_RTI: state_next = tms ? jpe_pkg::JPE_SEL_DR : jpe_pkg::JPE_RTI;
      jpe_pkg::JPE_SEL_DR: state_next = tms ? jpe_pkg::JPE_SEL_IR : jpe_pkg::JPE_CAP_DR;
      jpe_pkg::JPE_CAP_DR: state_next = tms ? jpe_pkg::JPE_EX1_DR : jpe_pkg::JPE_SH_DR;
      jpe_pkg::JPE_SH_DR: state_next = tms ? jpe_pkg::JPE_EX1_DR : jpe_pkg::JPE_SH_DR;
      jpe_pkg::JPE_EX1_DR: state_next = tms ? jpe_pkg::JPE_UPD_DR : jpe_pkg::JPE_PA_DR;
      jpe_pkg::JPE_PA_DR: state_next = tms ? jpe_pkg::JPE_EX2_DR : jpe_pkg::JPE_PA_DR;
      jpe_pkg::JPE_EX2_DR: state_next = tms ? jpe_pkg::JPE_UPD_DR : jpe_pkg::JPE_SH_DR;
      jpe_pkg::JPE_UPD_DR: state_next = tms ? jpe_pkg::JPE_SEL_DR : jpe_pkg::JPE_RTI;
      jpe_pkg::JPE_SEL_IR: state_next = tms ? jpe_pkg::JPE_TLR : jpe_pkg::JPE_CAP_IR;
      jpe_pkg::JPE_CAP_IR: state_next = tms ? jpe_pkg::JPE_EX1_IR : jpe_pkg::JPE_SH_IR;
      jpe_pkg::JPE_SH_IR: state_next = tms ? jpe_pkg::JPE_EX1_IR : jpe_pkg::JPE_SH_IR;
      jpe_pkg::JPE_EX1_IR: state_next = tms ? jpe_pkg::JPE_UPD_IR : jpe_pkg::JPE_PA_IR;
      jpe_pkg::JPE_PA_IR: state_next = tms ? jpe_pkg::JPE_EX2_IR : jpe_pkg::JPE_PA_IR;
      jpe_pkg::JPE_EX2_IR: state_next = tms ? jpe_pkg::JPE_UPD_IR : jpe_pkg::JPE_SH_IR;
      jpe_pkg::JPE_UPD_IR: state_next = tms ? jpe_pkg::JPE_SEL_DR : jpe_pkg::JPE_RTI;
    endcase
  end

  // held in reset while the port is not enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= jpe_pkg::JPE_TLR;
    end else if (!run) begin
      state_reg <= jpe_pkg::JPE_TLR;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  assign state = state_reg;
endmodule

// File: src/jpe_top.sv
`timescale 1ns/100ps
module jpe_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic nvm_dedicate_bit,
  input wire logic device_blank,
  input wire logic security_bit,
  input wire logic [11:0] sector_protect,
  input wire logic term_pin_select,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic mem_busy,
  input wire logic mem_op_done,
  input wire logic mem_op_fail,
  input wire logic mem_op_is_flash,
  output jpe_pkg::jpe_memop_s mem_op,
  output logic security_clear,
  input wire logic pin_tms,
  input wire logic pin_tck,
  input wire logic pin_tdi,
  output logic pin_tdo,
  output logic pin_tdo_oe,
  output logic jtag_pins_active,
  output logic prog_status_out,
  output logic prog_status_oe,
  output logic prog_error_out,
  output logic prog_error_oe
);
  jpe_pkg::jpe_link_s link_in;
  jpe_pkg::jpe_link_s link;
  jpe_pkg::jpe_tap_e tap;
  logic tck_rise;
  logic tck_fall;
  logic rt_en_reg;
  logic term_meta_reg;
  logic term_sync_reg;
  logic jtag_on;
  logic run;
  logic cfg_mode_reg;
  logic sideband_reg;
  logic open_drain_reg;
  logic err_reg = 1'b0;
  logic exited_reg = 1'b0;
  logic tdo_reg;
  logic tdo_oe_reg;
  logic [7:0] ir_shift_reg;
  logic [7:0] ir_reg;
  logic [7:0] dr_shift_reg;
  logic bypass_reg;
  jpe_pkg::jpe_memop_s mem_op_reg;
  logic sec_clr_reg;
  logic pins_active_reg;
  logic stat_out_reg;
  logic stat_oe_reg;
  logic err_out_reg;
  logic err_oe_reg;
  logic [7:0] rdata_reg;

  // command allowed by the security and protection gates
  function automatic logic cmd_allowed(input logic [7:0] op, input logic secure, input logic prot);
    logic ok;
    ok = 1'b1;
    if (secure && op != jpe_pkg::JPE_OP_CHIP_ERASE && op != jpe_pkg::JPE_OP_ENTRY &&
        op != jpe_pkg::JPE_OP_EXIT && op != jpe_pkg::JPE_OP_CLEAR) begin
      ok = 1'b0;
    end
    if (op == jpe_pkg::JPE_OP_SECT_ERASE && prot) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  assign link_in = '{tms: pin_tms, tck: pin_tck, tdi: pin_tdi};

  jpe_sync u_sync (
    .clk(clk),
    .rst(rst),
    .din(link_in),
    .dout(link),
    .tck_rise(tck_rise),
    .tck_fall(tck_fall)
  );

  // runtime enable register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rt_en_reg <= jpe_pkg::JPE_RT_EN_RESET[jpe_pkg::JPE_RT_EN_BIT];
    end else if (reg_wr && reg_addr == jpe_pkg::JPE_RT_EN_OFFSET) begin
      rt_en_reg <= reg_wdata[jpe_pkg::JPE_RT_EN_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd && reg_addr == jpe_pkg::JPE_RT_EN_OFFSET) begin
      rdata_reg <= {7'h00, rt_en_reg} & jpe_pkg::JPE_RT_EN_MASK;
    end else if (reg_rd) begin
      rdata_reg <= 8'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      term_meta_reg <= 1'b0;
      term_sync_reg <= 1'b0;
    end else begin
      term_meta_reg <= term_pin_select;
      term_sync_reg <= term_meta_reg;
    end
  end

  // dedicate bit and blank device keep run high through reset and re-enable the port after it
  assign jtag_on = nvm_dedicate_bit | device_blank | rt_en_reg | term_sync_reg;
  assign run = jtag_on & ~(rst & ~(nvm_dedicate_bit | device_blank));

  jpe_tap u_tap (
    .clk(clk),
    .rst(rst),
    .run(run),
    .tms(link.tms),
    .tck_rise(tck_rise),
    .state(tap)
  );

  // instruction and data shifting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_shift_reg <= 8'h00;
      ir_reg <= jpe_pkg::JPE_OP_BYPASS;
      dr_shift_reg <= 8'h00;
      bypass_reg <= 1'b0;
    end else if (!run) begin
      ir_reg <= jpe_pkg::JPE_OP_BYPASS;
    end else if (tck_rise) begin
      unique case (tap)
        jpe_pkg::JPE_CAP_IR: ir_shift_reg <= jpe_pkg::JPE_IR_CAPTURE;
        jpe_pkg::JPE_SH_IR: ir_shift_reg <= {link.tdi, ir_shift_reg[7:1]};
        jpe_pkg::JPE_CAP_DR: dr_shift_reg <= {7'h00, ~mem_busy};
        jpe_pkg::JPE_SH_DR: begin
          dr_shift_reg <= {link.tdi, dr_shift_reg[7:1]};
          bypass_reg <= link.tdi;
        end
        jpe_pkg::JPE_TLR: ir_reg <= jpe_pkg::JPE_OP_BYPASS;
        default: ;
      endcase
    end else if (tck_fall && tap == jpe_pkg::JPE_UPD_IR) begin
      ir_reg <= ir_shift_reg;
    end
  end

  // configuration mode, side-band options and memory commands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_mode_reg <= 1'b0;
      sideband_reg <= 1'b0;
      open_drain_reg <= 1'b0;
      mem_op_reg <= '0;
      sec_clr_reg <= 1'b0;
    end else begin
      mem_op_reg.start <= 1'b0;
      sec_clr_reg <= 1'b0;
      if (!run) begin
        cfg_mode_reg <= 1'b0;
      end else if (tck_fall && tap == jpe_pkg::JPE_UPD_DR &&
                   cmd_allowed(ir_reg, security_bit, sector_protect[dr_shift_reg[3:0]])) begin
        unique case (ir_reg)
          jpe_pkg::JPE_OP_ENTRY: begin
            cfg_mode_reg <= 1'b1;
            sideband_reg <= dr_shift_reg[jpe_pkg::JPE_OPT_SIDEBAND];
            open_drain_reg <= dr_shift_reg[jpe_pkg::JPE_OPT_OPEN_DRAIN];
          end
          jpe_pkg::JPE_OP_EXIT: cfg_mode_reg <= 1'b0;
          jpe_pkg::JPE_OP_CHIP_ERASE: begin
            mem_op_reg <= '{start: 1'b1, is_erase: 1'b1, is_program: 1'b0, is_chip: 1'b1, sector: 4'h0};
            sec_clr_reg <= 1'b1;
          end
          jpe_pkg::JPE_OP_SECT_ERASE, jpe_pkg::JPE_OP_PROGRAM: begin
            if (cfg_mode_reg) begin
              mem_op_reg <= '{start: 1'b1, is_erase: ir_reg == jpe_pkg::JPE_OP_SECT_ERASE,
                              is_program: ir_reg == jpe_pkg::JPE_OP_PROGRAM, is_chip: 1'b0,
                              sector: dr_shift_reg[3:0]};
            end
          end
          default: ;
        endcase
      end
    end
  end

  // error flag: set wins over clear; it outlives a reset unless exit came first
  always_ff @(posedge clk) begin
    if (rst) begin
      if (exited_reg) begin
        err_reg <= 1'b0;
        exited_reg <= 1'b0;
      end
    end else begin
      if (tck_fall && tap == jpe_pkg::JPE_UPD_DR && ir_reg == jpe_pkg::JPE_OP_EXIT) begin
        exited_reg <= 1'b1;
      end else if (tck_fall && tap == jpe_pkg::JPE_UPD_DR && ir_reg == jpe_pkg::JPE_OP_ENTRY) begin
        exited_reg <= 1'b0;
      end
      if (mem_op_done && mem_op_fail && mem_op_is_flash) begin
        err_reg <= 1'b1;
      end else if (tck_fall && tap == jpe_pkg::JPE_UPD_DR && ir_reg == jpe_pkg::JPE_OP_CLEAR) begin
        err_reg <= 1'b0;
      end
    end
  end

  // pin drivers, all registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
      pins_active_reg <= 1'b0;
      stat_out_reg <= 1'b1;
      stat_oe_reg <= 1'b0;
      err_out_reg <= 1'b1;
      err_oe_reg <= 1'b0;
    end else begin
      pins_active_reg <= jtag_on;
      tdo_oe_reg <= run & cfg_mode_reg & (tap == jpe_pkg::JPE_SH_DR || tap == jpe_pkg::JPE_SH_IR);
      if (tck_fall) begin
        tdo_reg <= (tap == jpe_pkg::JPE_SH_IR) ? ir_shift_reg[0] :
                   (ir_reg == jpe_pkg::JPE_OP_BYPASS) ? bypass_reg : dr_shift_reg[0];
      end
      stat_out_reg <= open_drain_reg ? 1'b0 : ~mem_busy;
      stat_oe_reg <= run & cfg_mode_reg & sideband_reg & (open_drain_reg ? mem_busy : 1'b1);
      err_out_reg <= open_drain_reg ? 1'b0 : ~err_reg;
      err_oe_reg <= run & cfg_mode_reg & sideband_reg & (open_drain_reg ? err_reg : 1'b1);
    end
  end

  assign reg_rdata = rdata_reg;
  assign mem_op = mem_op_reg;
  assign security_clear = sec_clr_reg;
  assign pin_tdo = tdo_reg;
  assign pin_tdo_oe = tdo_oe_reg;
  assign jtag_pins_active = pins_active_reg;
  assign prog_status_out = stat_out_reg;
  assign prog_status_oe = stat_oe_reg;
  assign prog_error_out = err_out_reg;
  assign prog_error_oe = err_oe_reg;
endmodule

// File: bench/jpe_checker.sv
`timescale 1ns/100ps
module jpe_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic nvm_dedicate_bit,
  input wire logic security_bit,
  input wire logic [11:0] sector_protect,
  input wire logic term_pin_select,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic mem_busy,
  input wire logic mem_op_done,
  input wire logic mem_op_fail,
  input wire logic mem_op_is_flash,
  input wire jpe_pkg::jpe_memop_s mem_op,
  input wire logic jtag_pins_active,
  input wire logic pin_tdo_oe,
  input wire logic prog_status_out,
  input wire logic prog_status_oe,
  input wire logic prog_error_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rt_set;
    reg_wr && reg_addr == 8'hc7 && reg_wdata[0];
  endsequence
  sequence s_ee_fail;
    mem_op_done && mem_op_fail && !mem_op_is_flash;
  endsequence
  a_dedicate_holds_on: assert property (nvm_dedicate_bit [*3] |-> jtag_pins_active)
    else $error("dedicate bit set but pins not active");
  a_runtime_turns_on: assert property (s_rt_set |-> ##[1:2] jtag_pins_active)
    else $error("runtime enable write did not activate pins");
  a_term_turns_on: assert property (term_pin_select [*4] |=> jtag_pins_active)
    else $error("product term held but pins not active");
  a_rdata_upper_zero: assert property (reg_rd |=> reg_rdata[7:1] == 7'h00)
    else $error("unused register bits read nonzero");
  a_tdo_released: assert property (!jtag_pins_active [*2] |-> !pin_tdo_oe)
    else $error("data out driven while pins released");
  a_eeprom_no_error: assert property (s_ee_fail |=> $stable(prog_error_out) [*3])
    else $error("eeprom failure moved the error output");
  a_protect_blocks: assert property (mem_op.start && mem_op.is_erase && !mem_op.is_chip
    |-> !sector_protect[mem_op.sector])
    else $error("erase issued to a protected sector");
  a_secure_chip_only: assert property (security_bit && mem_op.start |-> mem_op.is_chip && mem_op.is_erase)
    else $error("secured device issued a non chip erase operation");
  a_busy_status_low: assert property (prog_status_oe && mem_busy [*2] |-> !prog_status_out)
    else $error("status output high while memory busy");
endmodule

// File: bench/jpe_prog_model.sv
`timescale 1ns/100ps
module jpe_prog_model (
  output logic tms,
  output logic tck,
  output logic tdi,
  output logic cable_enable_n
);
  initial begin
    tms = 1'b1;
    tck = 1'b0;
    tdi = 1'b0;
    cable_enable_n = 1'b1;
  end
  // active-low cable enable, meant to feed the product term
  task automatic attach(input logic on);
    cable_enable_n = ~on;
  endtask
  // one test clock period; clock idles low between frames
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #200 tck = 1'b1;
    #200 tck = 1'b0;
  endtask
  // eight bits lsb first, last with mode high, then update and idle
  task automatic shift8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) step(i == 7, v[i]);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] dr);
    #7;
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    shift8(op);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    shift8(dr);
    tdi = ~tdi;
  endtask
endmodule

// File: bench/jtag_pin_enable_and_status_bench.sv
`timescale 1ns/100ps
module jtag_pin_enable_and_status_bench;
  logic clk, rst, nvm, blank, secure, busy, done, fail, flash, wr, rd, look, term;
  logic tms, tck, tdi, tdo, tdo_oe, act, st, st_oe, er, er_oe, sclr, cable_n;
  logic oe_seen, tdo_seen;
  logic [11:0] prot;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] n_op;
  logic [1:0] n_clr;
  logic [19:0] obs;
  logic [39:0] exp_q[$];
  jpe_pkg::jpe_memop_s op;
  int err_total, checks_done, seed;
  logic [7:0] blocked [4] = '{8'h13, 8'h14, 8'h15, 8'h12};
  assign obs = {rdata, act, tdo_oe, st, st_oe, er, er_oe, n_op, n_clr};
  jpe_top u_dut (.clk(clk), .rst(rst), .nvm_dedicate_bit(nvm), .device_blank(blank), .security_bit(secure),
    .sector_protect(prot), .term_pin_select(term), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .mem_busy(busy), .mem_op_done(done), .mem_op_fail(fail),
    .mem_op_is_flash(flash), .mem_op(op), .security_clear(sclr), .pin_tms(tms), .pin_tck(tck),
    .pin_tdi(tdi), .pin_tdo(tdo), .pin_tdo_oe(tdo_oe), .jtag_pins_active(act), .prog_status_out(st),
    .prog_status_oe(st_oe), .prog_error_out(er), .prog_error_oe(er_oe));
  jpe_prog_model u_prog (.tms(tms), .tck(tck), .tdi(tdi), .cable_enable_n(cable_n));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) term <= ~cable_n;
  always @(posedge clk) begin
    if (op.start) n_op <= n_op + 4'h1;
    if (sclr) n_clr <= n_clr + 2'h1;
    if (tdo_oe) oe_seen <= 1'b1;
    if (tdo_oe && tdo) tdo_seen <= 1'b1;
  end
  always @(posedge clk) begin
    logic [39:0] e;
    if (look && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      checks_done++;
      if ((obs & e[39:20]) !== e[19:0]) begin
        err_total++;
        $display("[ERR] %0t exp %h got %h", $time, e[19:0], obs & e[39:20]);
      end
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [19:0] m, input logic [19:0] v);
    exp_q.push_back({m, v});
    look <= 1'b1;
    @(posedge clk);
    look <= 1'b0;
    @(posedge clk);
  endtask
  task automatic flag_chk(input logic [1:0] e);
    checks_done++;
    if ({oe_seen, tdo_seen} !== e) begin
      err_total++;
      $display("[ERR] %0t exp %h got %h", $time, e, {oe_seen, tdo_seen});
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    chk(20'hf_f000, {e, 12'h000});
  endtask
  task automatic do_rst;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic mem_fail(input logic fl);
    done <= 1'b1;
    fail <= 1'b1;
    flash <= fl;
    @(posedge clk);
    done <= 1'b0;
    fail <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic run_cmd(input logic [7:0] o, input logic [7:0] d);
    u_prog.cmd(o, d);
    repeat (4) @(posedge clk);
  endtask
  initial begin
    #3_000_000;
    err_total++;
    wrap_up;
  end
  initial begin
    seed = 38;
    {rst, nvm, blank, secure, busy, done, fail, flash, wr, rd, look, term} = 12'h800;
    {prot, addr, wdata, n_op, n_clr} = {12'h004, 8'h00, 8'h00, 4'h0, 2'h0};
    {oe_seen, tdo_seen} = 2'b00;
    err_total = 0;
    checks_done = 0;
    do_rst;
    chk(20'h0_0fc0, 20'h0_0280);
    rreg(8'hc7, 8'h00);
    $display("reset state done");
    wreg(8'hc7, 8'($random(seed)) | 8'h01);
    chk(20'h0_0c00, 20'h0_0800);
    rreg(8'hc7, 8'h01);
    wreg({1'b0, 7'($random(seed))}, 8'h00);
    rreg({1'b0, 7'($random(seed))}, 8'h00);
    chk(20'h0_0800, 20'h0_0800);
    wreg(8'hc7, 8'h00);
    chk(20'h0_0800, 20'h0_0000);
    wreg(8'hc7, 8'h01);
    do_rst;
    chk(20'h0_0800, 20'h0_0000);
    $display("runtime enable done");
    u_prog.attach(1'b1);
    repeat (5) @(posedge clk);
    chk(20'h0_0800, 20'h0_0800);
    u_prog.attach(1'b0);
    repeat (5) @(posedge clk);
    chk(20'h0_0800, 20'h0_0000);
    for (int k = 0; k < 2; k++) begin
      nvm <= (k == 0);
      blank <= (k == 1);
      wreg(8'hc7, 8'h00);
      do_rst;
      chk(20'h0_0800, 20'h0_0800);
    end
    nvm <= 1'b0;
    blank <= 1'b0;
    $display("pin sources done");
    wreg(8'hc7, 8'h01);
    run_cmd(8'h0c, 8'h01);
    flag_chk(2'b00);
    chk(20'h0_03c0, 20'h0_03c0);
    busy <= 1'b1;
    repeat (3) @(posedge clk);
    chk(20'h0_03c0, 20'h0_01c0);
    busy <= 1'b0;
    mem_fail(1'b0);
    chk(20'h0_03c0, 20'h0_03c0);
    mem_fail(1'b1);
    chk(20'h0_03c0, 20'h0_0340);
    run_cmd(8'h10, 8'h00);
    flag_chk(2'b11);
    chk(20'h0_03c0, 20'h0_03c0);
    run_cmd(8'h0c, 8'h03);
    chk(20'h0_03c0, 20'h0_0000);
    busy <= 1'b1;
    repeat (3) @(posedge clk);
    chk(20'h0_03c0, 20'h0_0100);
    busy <= 1'b0;
    $display("side band done");
    run_cmd(8'h12, 8'h02);
    run_cmd(8'h12, 8'(3 + {$random(seed)} % 8));
    chk(20'h0_003f, 20'h0_0004);
    run_cmd(8'h00, 8'h00);
    run_cmd(8'hff, 8'h00);
    chk(20'h0_003f, 20'h0_0004);
    secure <= 1'b1;
    foreach (blocked[i]) run_cmd(blocked[i], 8'h07);
    run_cmd(8'h11, 8'h00);
    chk(20'h0_003f, 20'h0_0009);
    secure <= 1'b0;
    mem_fail(1'b1);
    chk(20'h0_00c0, 20'h0_0040);
    do_rst;
    chk(20'h0_00c0, 20'h0_0000);
    wreg(8'hc7, 8'h01);
    run_cmd(8'h0f, 8'h00);
    do_rst;
    chk(20'h0_0080, 20'h0_0080);
    $display("commands done");
    wrap_up;
  end
endmodule
bind jpe_top jpe_checker u_chk (.clk(clk), .rst(rst), .nvm_dedicate_bit(nvm_dedicate_bit),
  .security_bit(security_bit), .sector_protect(sector_protect), .term_pin_select(term_pin_select),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .mem_busy(mem_busy), .mem_op_done(mem_op_done), .mem_op_fail(mem_op_fail),
  .mem_op_is_flash(mem_op_is_flash), .mem_op(mem_op), .jtag_pins_active(jtag_pins_active),
  .pin_tdo_oe(pin_tdo_oe), .prog_status_out(prog_status_out), .prog_status_oe(prog_status_oe),
  .prog_error_out(prog_error_out));
